// ===== inc/descriptor_rom_pkg.sv
// Constants, default word image and types for the default descriptor store
package descriptor_rom_pkg;
   localparam int ADDR_W = 8;
   localparam int WORD_W = 16;
   localparam int BUS_ADDR_W = 9;
   // Store addresses
   localparam logic [7:0] ADDR_PWR_MODE = 8'h01;
   localparam logic [7:0] ADDR_PHY_SAVE = 8'h18;
   localparam logic [7:0] ADDR_SERIAL_FIRST = 8'h19;
   localparam logic [7:0] ADDR_SERIAL_LAST = 8'h1f;
   localparam logic [7:0] ADDR_HS_ATTR = 8'h2c;
   localparam logic [7:0] ADDR_HS_MAXPWR = 8'h2d;
   localparam logic [7:0] ADDR_FS_ATTR = 8'h4c;
   localparam logic [7:0] ADDR_FS_MAXPWR = 8'h4d;
   localparam logic [7:0] ADDR_MFG_FIRST = 8'h60;
   localparam logic [7:0] ADDR_MFG_LAST = 8'h70;
   localparam logic [7:0] ADDR_PROD_FIRST = 8'h71;
   localparam logic [7:0] ADDR_PROD_LAST = 8'h79;
   // Field positions and fixed values
   localparam int ATTR_ONE_BIT = 7;
   localparam int ATTR_SELF_BIT = 6;
   localparam int ATTR_WAKE_BIT = 5;
   localparam logic [7:0] ATTR_DEFAULT = 8'he0;
   localparam logic [7:0] MAXPWR_DEFAULT = 8'h02;
   localparam logic [7:0] STRING_TYPE = 8'h03;
   localparam logic [7:0] PHY_SAVE_DEFAULT = 8'h08;
   localparam logic [15:0] PWR_MODE_DEFAULT = 16'h1dfd;
   localparam int PWR_SELF_BIT = 0;
   localparam int PWR_WAKE_BIT = 2;
   localparam int PWR_PME_BIT = 3;
   localparam int DETACH_BIT = 8;
   localparam int SAVE_LEVEL_LSB = 9;
   localparam int SAVE_LEVEL_W = 2;
   // Bus map above the store window
   localparam logic [8:0] REG_CTRL = 9'h100;
   localparam logic [8:0] REG_STATUS = 9'h101;
   localparam logic [8:0] REG_POWER = 9'h102;
   localparam logic [8:0] REG_PWR_MODE = 9'h103;
   localparam logic [8:0] REG_PHY_SAVE = 9'h104;
   localparam logic [15:0] CTRL_RESET = 16'h0001;
   localparam int CTRL_HS_BIT = 0;
   // Words copied at start-up, by index
   localparam int FETCH_COUNT = 6;
   localparam logic [2:0] FETCH_LAST = 3'h5;
   // Identity words: values are arbitrary
   localparam logic [15:0] VENDOR_WORD = 16'h1234;
   localparam logic [15:0] PRODUCT_WORD = 16'h5678;
   localparam logic [15:0] NODE_WORD0 = 16'h2211;
   localparam logic [15:0] NODE_WORD1 = 16'h4433;
   localparam logic [15:0] NODE_WORD2 = 16'h6655;
   localparam logic [15:0] BLANK_WORD = 16'hffff;
   localparam logic [15:0] DEFAULT_WORDS [0:127] = '{
      16'h0015, 16'h1dfd, 16'h1220, 16'h2729, NODE_WORD0, NODE_WORD1,
      NODE_WORD2, 16'h0409,
      16'h2260, 16'h1271, 16'h0e19, 16'h043d, 16'h043d, 16'h043d,
      16'h043d, 16'h0580,
      16'h0600, 16'he010, 16'h2442, 16'h1240, 16'h2749, 16'hffff,
      16'h0000, 16'hffff,
      16'h08ff, 16'h030e, 16'h0030, 16'h0030, 16'h0030, 16'h0030,
      16'h0030, 16'h0031,
      16'h0112, 16'h0200, 16'hffff, 16'h4000, VENDOR_WORD,
      PRODUCT_WORD, 16'h0002, 16'h0201,
      16'h0103, 16'h0209, 16'h0027, 16'h0101, 16'he004, 16'h0902,
      16'h0004, 16'h0300,
      16'hffff, 16'h0700, 16'h0507, 16'h0381, 16'h0008, 16'h070b,
      16'h8205, 16'h0002,
      16'h0002, 16'h0507, 16'h0203, 16'h0200, 16'hff00, 16'h0304,
      16'h0030, 16'hffff,
      16'h0112, 16'h0200, 16'hffff, 16'h0800, VENDOR_WORD,
      PRODUCT_WORD, 16'h0002, 16'h0201,
      16'h0103, 16'h0209, 16'h0027, 16'h0101, 16'he004, 16'h0902,
      16'h0004, 16'h0300,
      16'hffff, 16'h0700, 16'h0507, 16'h0381, 16'h0008, 16'h07a0,
      16'h8205, 16'h4002,
      16'h0000, 16'h0507, 16'h0203, 16'h0040, 16'hdd00, 16'hffff,
      16'haaaa, 16'hbbbb,
      16'h0322, 16'h0041, 16'h0053, 16'h0049, 16'h0058, 16'h0020,
      16'h0045, 16'h006c,
      16'h0065, 16'h0063, 16'h002e, 16'h0020, 16'h0043, 16'h006f,
      16'h0072, 16'h0070,
      16'h002e, 16'h0312, 16'h0041, 16'h0058, 16'h0038, 16'h0038,
      16'h0037, 16'h0037,
      16'h0032, 16'h0042, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'hffff, 16'hffff
   };
   typedef enum logic [2:0] {
      ST_WAIT, ST_FETCH, ST_DRAIN, ST_READY
   } load_state_t;
endpackage

// ===== hw/default_word_table.sv
// Fixed default word store with two read ports and no write path
`timescale 1ns/1ps
module default_word_table (
   input wire logic [7:0] bus_addr,
   output logic [15:0] bus_word,
   input wire logic [7:0] desc_addr,
   output logic [15:0] desc_word
);
   // Upper half of the address space reads as blank
   function automatic logic [15:0] word_at(input logic [7:0] a);
      if (a[7]) begin
         return descriptor_rom_pkg::BLANK_WORD;
      end
      return descriptor_rom_pkg::DEFAULT_WORDS[a[6:0]];
   endfunction

   always_comb begin
      bus_word = word_at(bus_addr);
      desc_word = word_at(desc_addr);
   end
endmodule

// ===== hw/default_descriptor_rom.sv
// Start-up configuration loader with fixed default descriptor store
`timescale 1ns/1ps
// Behaviour
// - The default store is read-only and no write can change any word.
// - Each address returns one 16-bit word, first byte low, second high.
// - A blank EEPROM or a bad checksum makes the loader use the defaults.
// - Word 0x01 selects self or bus power, remote wakeup and power events.
// - High byte of 0x2C (0x4C at full speed) is the attribute byte, E0.
// - The attribute byte keeps bit 7 set, bits 6 and 5 as set, 4..0 clear.
// - Low byte of 0x2D (0x4D at full speed) is the maximum power byte.
// - The maximum power byte counts 2 mA units, so 02 means 4 mA.
// - The maker string sits at 0x60..0x70, length then type 03, UTF-16LE.
// - The product string sits at 0x71..0x79, length then type 03.
// - The serial string sits at 0x19..0x1F, 14 bytes of type 03.
// - High byte of 0x18 holds PHY power saving, 08 meaning detach off.
// - Losing external power clears the reported self-powered status.
// - Without external power the draw stays in limit, and ops fail if word 0x01 and the attribute byte both select self power.
module default_descriptor_rom (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [8:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic ee_status_valid,
   input wire logic ee_blank,
   input wire logic ee_checksum_ok,
   output logic ee_rd,
   output logic [7:0] ee_addr,
   input wire logic [15:0] ee_data,
   input wire logic desc_req,
   input wire logic [7:0] desc_addr,
   output logic desc_valid,
   output logic [15:0] desc_data,
   input wire logic ext_power_ok,
   output logic cfg_ready,
   output logic use_default,
   output logic [7:0] attr_byte,
   output logic [7:0] max_power_byte,
   output logic [8:0] bus_limit_ma,
   output logic self_powered_now,
   output logic ops_fail,
   output logic remote_wakeup_en,
   output logic power_mgmt_event_en,
   output logic cable_off_detach,
   output logic [1:0] save_level
);
   logic rst_meta_reg;
   logic rst_n_reg;
   descriptor_rom_pkg::load_state_t state_reg;
   logic use_default_reg;
   logic [2:0] fetch_idx_reg;
   logic [15:0] ctrl_reg;
   logic p1_valid_reg;
   logic p1_fetch_reg;
   logic [7:0] p1_addr_reg;
   logic [2:0] p1_idx_reg;
   logic p2_valid_reg;
   logic p2_fetch_reg;
   logic [7:0] p2_addr_reg;
   logic [2:0] p2_idx_reg;
   logic [15:0] cfg_word_reg [0:5];
   logic [15:0] rom_bus_word;
   logic [15:0] rom_desc_word;
   logic [15:0] pick_word;
   logic issue_fetch;
   logic issue_desc;
   logic [7:0] issue_addr;
   logic hs_sel;
   logic [7:0] attr_sel;
   logic [7:0] maxp_sel;
   logic last_fetch_in;

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   default_word_table u_table (
      .bus_addr(reg_addr[7:0]),
      .bus_word(rom_bus_word),
      .desc_addr(p2_addr_reg),
      .desc_word(rom_desc_word)
   );

   // Reported attribute byte always has the fixed bits forced
   function automatic logic [7:0] attr_fix(input logic [7:0] b);
      attr_fix = {1'b1, b[descriptor_rom_pkg::ATTR_SELF_BIT],
         b[descriptor_rom_pkg::ATTR_WAKE_BIT], 5'h00};
   endfunction

   function automatic logic [7:0] fetch_addr(input logic [2:0] idx);
      case (idx)
         3'h0: fetch_addr = descriptor_rom_pkg::ADDR_PWR_MODE;
         3'h1: fetch_addr = descriptor_rom_pkg::ADDR_PHY_SAVE;
         3'h2: fetch_addr = descriptor_rom_pkg::ADDR_HS_ATTR;
         3'h3: fetch_addr = descriptor_rom_pkg::ADDR_HS_MAXPWR;
         3'h4: fetch_addr = descriptor_rom_pkg::ADDR_FS_ATTR;
         default: fetch_addr = descriptor_rom_pkg::ADDR_FS_MAXPWR;
      endcase
   endfunction

   function automatic logic is_attr(input logic [7:0] a);
      is_attr = (a == descriptor_rom_pkg::ADDR_HS_ATTR) ||
         (a == descriptor_rom_pkg::ADDR_FS_ATTR);
   endfunction

   always_comb begin
      issue_fetch = (state_reg == descriptor_rom_pkg::ST_FETCH);
      issue_desc = desc_req && (state_reg == descriptor_rom_pkg::ST_READY);
      issue_addr = issue_fetch ? fetch_addr(fetch_idx_reg) : desc_addr;
      // Source chosen by the single start-up decision
      pick_word = use_default_reg ? rom_desc_word : ee_data;
      if (is_attr(p2_addr_reg)) begin
         pick_word = {attr_fix(pick_word[15:8]), pick_word[7:0]};
      end
      last_fetch_in = p2_valid_reg && p2_fetch_reg &&
         (p2_idx_reg == descriptor_rom_pkg::FETCH_LAST);
      hs_sel = ctrl_reg[descriptor_rom_pkg::CTRL_HS_BIT];
      attr_sel = hs_sel ? cfg_word_reg[2][15:8] : cfg_word_reg[4][15:8];
      maxp_sel = hs_sel ? cfg_word_reg[3][7:0] : cfg_word_reg[5][7:0];
   end

   // Start-up sequence
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= descriptor_rom_pkg::ST_WAIT;
         use_default_reg <= 1'b1;
         fetch_idx_reg <= 3'h0;
      end else begin
         case (state_reg)
            descriptor_rom_pkg::ST_WAIT: begin
               if (ee_status_valid) begin
                  use_default_reg <= ee_blank || !ee_checksum_ok;
                  state_reg <= descriptor_rom_pkg::ST_FETCH;
               end
            end
            descriptor_rom_pkg::ST_FETCH: begin
               fetch_idx_reg <= fetch_idx_reg + 3'h1;
               if (fetch_idx_reg == descriptor_rom_pkg::FETCH_LAST) begin
                  state_reg <= descriptor_rom_pkg::ST_DRAIN;
               end
            end
            descriptor_rom_pkg::ST_DRAIN: begin
               if (last_fetch_in) begin
                  state_reg <= descriptor_rom_pkg::ST_READY;
               end
            end
            descriptor_rom_pkg::ST_READY: begin
               state_reg <= descriptor_rom_pkg::ST_READY;
            end
            default: begin
               state_reg <= descriptor_rom_pkg::ST_WAIT;
            end
         endcase
      end
   end

   // Word read pipeline shared by start-up fetch and descriptor reads
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ee_rd <= 1'b0;
         ee_addr <= 8'h00;
         p1_valid_reg <= 1'b0;
         p1_fetch_reg <= 1'b0;
         p1_addr_reg <= 8'h00;
         p1_idx_reg <= 3'h0;
         p2_valid_reg <= 1'b0;
         p2_fetch_reg <= 1'b0;
         p2_addr_reg <= 8'h00;
         p2_idx_reg <= 3'h0;
         desc_valid <= 1'b0;
         desc_data <= 16'h0000;
      end else begin
         ee_rd <= (issue_fetch || issue_desc) && !use_default_reg;
         ee_addr <= issue_addr;
         p1_valid_reg <= issue_fetch || issue_desc;
         p1_fetch_reg <= issue_fetch;
         p1_addr_reg <= issue_addr;
         p1_idx_reg <= fetch_idx_reg;
         p2_valid_reg <= p1_valid_reg;
         p2_fetch_reg <= p1_fetch_reg;
         p2_addr_reg <= p1_addr_reg;
         p2_idx_reg <= p1_idx_reg;
         desc_valid <= p2_valid_reg && !p2_fetch_reg;
         desc_data <= pick_word;
      end
   end

   // Settings words, addressed by fetch index
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         for (int i = 0; i < descriptor_rom_pkg::FETCH_COUNT; i++) begin
            cfg_word_reg[i] <= 16'h0000;
         end
      end else if (p2_valid_reg && p2_fetch_reg) begin
         cfg_word_reg[p2_idx_reg] <= pick_word;
      end
   end

   // Decoded settings and power status
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cfg_ready <= 1'b0;
         use_default <= 1'b0;
         attr_byte <= 8'h00;
         max_power_byte <= 8'h00;
         bus_limit_ma <= 9'h000;
         self_powered_now <= 1'b0;
         ops_fail <= 1'b0;
         remote_wakeup_en <= 1'b0;
         power_mgmt_event_en <= 1'b0;
         cable_off_detach <= 1'b0;
         save_level <= 2'h0;
      end else if (state_reg == descriptor_rom_pkg::ST_READY) begin
         cfg_ready <= 1'b1;
         use_default <= use_default_reg;
         attr_byte <= attr_sel;
         max_power_byte <= maxp_sel;
         bus_limit_ma <= {maxp_sel, 1'b0};
         // Self-powered only while both configured and supplied
         self_powered_now <= attr_sel[descriptor_rom_pkg::ATTR_SELF_BIT] &&
            cfg_word_reg[0][descriptor_rom_pkg::PWR_SELF_BIT] &&
            ext_power_ok;
         ops_fail <= attr_sel[descriptor_rom_pkg::ATTR_SELF_BIT] &&
            cfg_word_reg[0][descriptor_rom_pkg::PWR_SELF_BIT] &&
            !ext_power_ok;
         remote_wakeup_en <= attr_sel[descriptor_rom_pkg::ATTR_WAKE_BIT] &&
            cfg_word_reg[0][descriptor_rom_pkg::PWR_WAKE_BIT];
         power_mgmt_event_en <=
            cfg_word_reg[0][descriptor_rom_pkg::PWR_PME_BIT];
         cable_off_detach <=
            cfg_word_reg[1][descriptor_rom_pkg::DETACH_BIT];
         save_level <= cfg_word_reg[1][descriptor_rom_pkg::SAVE_LEVEL_LSB +:
            descriptor_rom_pkg::SAVE_LEVEL_W];
      end
   end

   // Only the control word takes writes; store window ignores them
   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ctrl_reg <= descriptor_rom_pkg::CTRL_RESET;
      end else if (reg_wr && reg_addr == descriptor_rom_pkg::REG_CTRL) begin
         ctrl_reg <= {15'h0000, reg_wdata[0]};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         if (!reg_addr[8]) begin
            reg_rdata <= rom_bus_word;
         end else begin
            case (reg_addr)
               descriptor_rom_pkg::REG_CTRL: reg_rdata <= ctrl_reg;
               descriptor_rom_pkg::REG_STATUS: begin
                  reg_rdata <= {12'h000, ops_fail, self_powered_now,
                     use_default, cfg_ready};
               end
               descriptor_rom_pkg::REG_POWER: begin
                  reg_rdata <= {attr_byte, max_power_byte};
               end
               descriptor_rom_pkg::REG_PWR_MODE: reg_rdata <= cfg_word_reg[0];
               descriptor_rom_pkg::REG_PHY_SAVE: reg_rdata <= cfg_word_reg[1];
               default: reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_n_reg);

   a_decide_once: assert property (
      cfg_ready |=> $stable(use_default) && $stable(use_default_reg))
      else $error("source decision changed after ready");

   a_fallback_blank: assert property (
      state_reg == descriptor_rom_pkg::ST_WAIT && ee_status_valid &&
      (ee_blank || !ee_checksum_ok) |=> use_default_reg && !ee_rd [*8])
      else $error("blank or bad EEPROM did not select defaults");

   a_store_readonly: assert property (
      reg_wr && !reg_addr[8] |=> $stable(ctrl_reg))
      else $error("write to store window changed state");

   a_pwr_word: assert property (
      reg_rd && reg_addr == {1'b0, descriptor_rom_pkg::ADDR_PWR_MODE}
      |=> reg_rdata == descriptor_rom_pkg::PWR_MODE_DEFAULT)
      else $error("power mode word wrong");

   a_attr_default: assert property (
      reg_rd && reg_addr == {1'b0, descriptor_rom_pkg::ADDR_FS_ATTR}
      |=> reg_rdata[15:8] == descriptor_rom_pkg::ATTR_DEFAULT)
      else $error("attribute byte default wrong");

   a_attr_shape: assert property (
      desc_valid && $past(is_attr(p2_addr_reg))
      |-> desc_data[15] && desc_data[12:8] == 5'h00)
      else $error("attribute byte fixed bits wrong");

   a_maxpwr_default: assert property (
      reg_rd && reg_addr == {1'b0, descriptor_rom_pkg::ADDR_HS_MAXPWR}
      |=> reg_rdata[7:0] == descriptor_rom_pkg::MAXPWR_DEFAULT)
      else $error("max power byte default wrong");

   a_limit_units: assert property (
      cfg_ready |-> bus_limit_ma == {max_power_byte, 1'b0})
      else $error("bus limit not twice the power byte");

   a_mfg_head: assert property (
      reg_rd && reg_addr == {1'b0, descriptor_rom_pkg::ADDR_MFG_FIRST}
      |=> reg_rdata[15:8] == descriptor_rom_pkg::STRING_TYPE)
      else $error("maker string type wrong");

   a_prod_head: assert property (
      reg_rd && reg_addr == {1'b0, descriptor_rom_pkg::ADDR_PROD_FIRST}
      |=> reg_rdata[15:8] == descriptor_rom_pkg::STRING_TYPE)
      else $error("product string type wrong");

   a_serial_head: assert property (
      reg_rd && reg_addr == {1'b0, descriptor_rom_pkg::ADDR_SERIAL_FIRST}
      |=> reg_rdata == 16'h030e)
      else $error("serial string header wrong");

   a_phy_save: assert property (
      reg_rd && reg_addr == {1'b0, descriptor_rom_pkg::ADDR_PHY_SAVE}
      |=> reg_rdata[15:8] == descriptor_rom_pkg::PHY_SAVE_DEFAULT)
      else $error("PHY saving byte wrong");

   a_power_loss: assert property (
      state_reg == descriptor_rom_pkg::ST_READY && !ext_power_ok
      |=> !self_powered_now)
      else $error("self-powered kept without supply");

   a_ops_fail: assert property (
      state_reg == descriptor_rom_pkg::ST_READY && !ext_power_ok &&
      attr_sel[descriptor_rom_pkg::ATTR_SELF_BIT] &&
      cfg_word_reg[0][descriptor_rom_pkg::PWR_SELF_BIT]
      |=> ops_fail && $stable(bus_limit_ma))
      else $error("power loss did not fail operations");

   a_desc_latency: assert property (
      issue_desc |-> ##3 desc_valid)
      else $error("descriptor answer not three cycles later");

   c_default_path: cover property (cfg_ready && use_default);
   c_eeprom_path: cover property (cfg_ready && !use_default);
   c_desc_read: cover property (desc_valid ##1 desc_valid);
   c_power_lost: cover property (ops_fail);
endmodule

// ===== sim/eeprom_side_model.sv
// Behavioural external EEPROM side answering the start-up loader
`timescale 1ns/1ps
module eeprom_side_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [1:0] ee_mode,
   input wire logic ee_rd,
   input wire logic [7:0] ee_addr,
   output logic ee_status_valid,
   output logic ee_blank,
   output logic ee_checksum_ok,
   output logic [15:0] ee_data
);
   logic [2:0] wait_reg;
   // Mode 0 is a blank part, 1 a bad checksum, 2 a good image
   assign ee_blank = (ee_mode == 2'h0);
   assign ee_checksum_ok = (ee_mode == 2'h2);
   assign ee_status_valid = (wait_reg == 3'h7);
   // The check result shows up some cycles after reset, as a slow read would
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= 3'h0;
      end else if (wait_reg != 3'h7) begin
         wait_reg <= wait_reg + 3'h1;
      end
   end
   // The word is valid for one cycle after a request only; the rest of the
   // time the line inverts every cycle, so a sample one cycle late reads the inverted word
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ee_data <= 16'h0000;
      end else if (ee_rd) begin
         ee_data <= {8'h3f, ee_addr};
      end else begin
         ee_data <= ~ee_data;
      end
   end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the default descriptor store and loader
`timescale 1ns/1ps
module tb_top;
   localparam int N_ROWS = 18;
   logic ref_clk, reset_n, reg_wr, reg_rd, desc_req, ext_power_ok;
   logic [8:0] reg_addr, bus_limit_ma;
   logic [15:0] reg_wdata, reg_rdata, ee_data, desc_data, word;
   logic ee_status_valid, ee_blank, ee_checksum_ok, ee_rd, desc_valid;
   logic [7:0] ee_addr, desc_addr, attr_byte, max_power_byte;
   logic cfg_ready, use_default, self_powered_now, ops_fail;
   logic remote_wakeup_en, power_mgmt_event_en, cable_off_detach;
   logic [1:0] save_level, ee_mode;
   int miscompares, n_tests, ee_reads;
   // Bus address beside the word it must read back
   logic [8:0] row_addr [N_ROWS] = '{9'h001, 9'h018, 9'h019, 9'h01f,
      9'h02c, 9'h02d, 9'h04c, 9'h04d, 9'h060, 9'h070, 9'h071, 9'h079,
      9'h100, 9'h101, 9'h102, 9'h103, 9'h104, 9'h105};
   logic [15:0] row_word [N_ROWS] = '{16'h1dfd, 16'h08ff, 16'h030e,
      16'h0031, 16'he004, 16'h0902, 16'he004, 16'h0902, 16'h0322,
      16'h002e, 16'h0312, 16'h0042, 16'h0001, 16'h0007, 16'he002,
      16'h1dfd, 16'h08ff, 16'h0000};

   default_descriptor_rom default_descriptor_rom_i (.ref_clk, .reset_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ee_status_valid, .ee_blank, .ee_checksum_ok, .ee_rd, .ee_addr,
      .ee_data, .desc_req, .desc_addr, .desc_valid, .desc_data,
      .ext_power_ok, .cfg_ready, .use_default, .attr_byte,
      .max_power_byte, .bus_limit_ma, .self_powered_now, .ops_fail,
      .remote_wakeup_en, .power_mgmt_event_en, .cable_off_detach,
      .save_level);
   eeprom_side_model eeprom_side_model_i (.ref_clk, .reset_n, .ee_mode,
      .ee_rd, .ee_addr, .ee_status_valid, .ee_blank, .ee_checksum_ok,
      .ee_data);

   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic bus_write(input logic [8:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask

   task automatic bus_read(input logic [8:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask

   // Answer must come exactly three cycles after the request cycle
   task automatic desc_read(input logic [7:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      desc_req <= 1'h1;
      desc_addr <= a;
      @(posedge ref_clk);
      desc_req <= 1'h0;
      @(posedge ref_clk);
      #1 check("desc early", 16'(desc_valid), 16'h0000);
      @(posedge ref_clk);
      #1 check("desc valid", 16'(desc_valid), 16'h0001);
      check("desc word", desc_data, exp);
   endtask

   task automatic restart(input logic [1:0] mode);
      int n;
      reset_n <= 1'h0;
      ee_mode <= mode;
      ee_reads = 0;
      repeat (4) @(posedge ref_clk);
      #1 check("ready in reset", 16'(cfg_ready), 16'h0000);
      check("attr in reset", 16'(attr_byte), 16'h0000);
      @(posedge ref_clk);
      reset_n <= 1'h1;
      n = 0;
      while (cfg_ready !== 1'h1 && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      #1 check("start-up done", 16'(cfg_ready), 16'h0001);
   endtask

   always @(posedge ref_clk) begin
      if (ee_rd === 1'h1) begin
         ee_reads++;
      end
   end

   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   initial begin
      #50000;
      miscompares++;
      complete_run;
   end

   initial begin
      reset_n = 1'h0;
      reg_addr = 9'h000;
      reg_wdata = 16'h0000;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      desc_req = 1'h0;
      desc_addr = 8'h00;
      ext_power_ok = 1'h1;
      ee_mode = 2'h0;
      miscompares = 0;
      n_tests = 0;
      restart(2'h0);
      check("blank uses store", 16'(use_default), 16'h0001);
      check("attr", 16'(attr_byte), 16'h00e0);
      check("max power", 16'(max_power_byte), 16'h0002);
      check("bus limit", 16'(bus_limit_ma), 16'h0004);
      check("self power", 16'(self_powered_now), 16'h0001);
      check("wakeup", 16'(remote_wakeup_en), 16'h0001);
      check("event", 16'(power_mgmt_event_en), 16'h0001);
      check("detach", 16'(cable_off_detach), 16'h0000);
      check("save level", 16'(save_level), 16'h0000);
      check("no eeprom reads", 16'(ee_reads), 16'h0000);
      for (int i = 0; i < N_ROWS; i++) begin
         bus_read(row_addr[i], word);
         check("bus word", word, row_word[i]);
         if (row_addr[i][8] == 1'h0) begin
            desc_read(row_addr[i][7:0], row_word[i]);
         end
      end
      bus_write(9'h001, 16'h0000);
      bus_write(9'h101, 16'hffff);
      bus_read(9'h001, word);
      check("store after write", word, 16'h1dfd);
      bus_read(9'h101, word);
      check("status after write", word, 16'h0007);
      bus_write(9'h100, 16'h0000);
      bus_read(9'h100, word);
      check("speed select", word, 16'h0000);
      check("full speed attr", 16'(attr_byte), 16'h00e0);
      @(posedge ref_clk);
      ext_power_ok <= 1'h0;
      repeat (3) @(posedge ref_clk);
      #1 check("self lost", 16'(self_powered_now), 16'h0000);
      check("ops fail", 16'(ops_fail), 16'h0001);
      check("limit kept", 16'(bus_limit_ma), 16'h0004);
      bus_read(9'h101, word);
      check("status lost", word, 16'h000b);
      @(posedge ref_clk);
      ext_power_ok <= 1'h1;
      restart(2'h1);
      check("bad sum uses store", 16'(use_default), 16'h0001);
      restart(2'h2);
      check("good image used", 16'(use_default), 16'h0000);
      check("eeprom reads", 16'(ee_reads), 16'h0006);
      // Image high byte 3f: bit 6 clear, bit 5 set, low bits forced clear
      check("attr forced", 16'(attr_byte), 16'h00a0);
      check("ee max power", 16'(max_power_byte), 16'h002d);
      check("ee limit", 16'(bus_limit_ma), 16'h005a);
      check("ee self", 16'(self_powered_now), 16'h0000);
      check("ee wakeup", 16'(remote_wakeup_en), 16'h0000);
      check("ee event", 16'(power_mgmt_event_en), 16'h0000);
      check("ee detach", 16'(cable_off_detach), 16'h0001);
      check("ee save", 16'(save_level), 16'h0003);
      desc_read(8'h2c, 16'ha02c);
      // Full-speed copy holds a different power byte in the image
      bus_write(9'h100, 16'h0000);
      repeat (2) @(posedge ref_clk);
      #1 check("ee fs power", 16'(max_power_byte), 16'h004d);
      check("ee fs limit", 16'(bus_limit_ma), 16'h009a);
      check("ee fs attr", 16'(attr_byte), 16'h00a0);
      bus_read(9'h001, word);
      check("bus keeps store", word, 16'h1dfd);
      complete_run;
   end
endmodule
